/* File: hw/brightness_pkg.sv */
`default_nettype none
package brightness_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CODE_W = 7;
  localparam int FRAC_W = 17;
  localparam int SINKS = 2;
  localparam int SINK_MAIN = 0;
  localparam int SINK_SECONDARY = 1;

  // Byte addresses of the 32-bit words
  localparam logic [ADDR_W-1:0] OFS_GENERAL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MAIN_SINK_LEVEL = 8'ha0;
  localparam logic [ADDR_W-1:0] OFS_SECONDARY_SINK_LEVEL = 8'hb0;

  // Control register fields
  localparam int BIT_MAIN_ENABLE = 0;
  localparam int BIT_SECONDARY_ENABLE = 1;
  localparam int BIT_SHARED_LEVEL_SELECT = 2;
  localparam int BIT_RAMP0 = 3;
  localparam int BIT_RAMP1 = 4;
  localparam int BIT_OLED_MODE = 5;
  localparam logic [7:0] GENERAL_STORED_MASK = 8'h3f;
  localparam logic [7:0] GENERAL_READ_ONES = 8'hc0;
  localparam logic [7:0] GENERAL_RESET = 8'hc0;

  // Brightness register fields
  localparam int LEVEL_MSB = 7;
  localparam logic [7:0] LEVEL_READ_ONES = 8'h80;
  localparam logic [7:0] LEVEL_RESET = 8'h80;
  localparam logic [CODE_W-1:0] CODE_RESET = 7'h00;

  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;
endpackage : brightness_pkg
`default_nettype wire

/* File: hw/level_map_if.sv */
`default_nettype none
interface level_map_if;
  import brightness_pkg::*;
  logic [CODE_W-1:0] code [SINKS];
  logic [FRAC_W-1:0] frac [SINKS];
  modport mapper (input code, output frac);
  modport user (output code, input frac);
endinterface : level_map_if
`default_nettype wire

/* File: hw/level_map.sv */
`default_nettype none
// Code to fraction of full-scale current, in thousandths of a percent
module level_map (
  level_map_if.mapper lm
);
  import brightness_pkg::*;

  localparam logic [FRAC_W-1:0] LUT [128] = '{
    17'd0, 17'd166, 17'd175, 17'd184, 17'd194, 17'd204, 17'd214, 17'd226,
    17'd237, 17'd250, 17'd263, 17'd276, 17'd291, 17'd306, 17'd322, 17'd339,
    17'd356, 17'd375, 17'd394, 17'd415, 17'd436, 17'd459, 17'd483, 17'd508,
    17'd535, 17'd563, 17'd592, 17'd623, 17'd655, 17'd689, 17'd725, 17'd763,
    17'd803, 17'd845, 17'd889, 17'd935, 17'd984, 17'd1035, 17'd1089,
    17'd1146, 17'd1205, 17'd1268, 17'd1334, 17'd1404, 17'd1477, 17'd1554,
    17'd1635, 17'd1720, 17'd1809, 17'd1904, 17'd2003, 17'd2107, 17'd2217,
    17'd2332, 17'd2454, 17'd2582, 17'd2716, 17'd2858, 17'd3007, 17'd3163,
    17'd3328, 17'd3502, 17'd3684, 17'd3876,
    17'd4078, 17'd4290, 17'd4514, 17'd4749, 17'd4996, 17'd5257, 17'd5531,
    17'd5819, 17'd6122, 17'd6441, 17'd6776, 17'd7129, 17'd7501, 17'd7892,
    17'd8303, 17'd8735, 17'd9191, 17'd9669, 17'd10173, 17'd10703,
    17'd11261, 17'd11847, 17'd12465, 17'd13114, 17'd13797, 17'd14516,
    17'd15272, 17'd16068, 17'd16905, 17'd17786, 17'd18713, 17'd19687,
    17'd20713, 17'd21792, 17'd22928, 17'd24122, 17'd25379, 17'd26701,
    17'd28092, 17'd29556, 17'd31096, 17'd32716, 17'd34420, 17'd36213,
    17'd38100, 17'd40085, 17'd42173, 17'd44371, 17'd46682, 17'd49114,
    17'd51673, 17'd54365, 17'd57198, 17'd60178, 17'd63313, 17'd66611,
    17'd70082, 17'd73733, 17'd77574, 17'd81616, 17'd85868, 17'd90341,
    17'd95048, 17'd100000
  };

  function automatic logic [FRAC_W-1:0] code_to_frac(
    input logic [CODE_W-1:0] code
  );
    code_to_frac = LUT[code];
  endfunction : code_to_frac

  for (genvar i = 0; i < SINKS; i++) begin : g_sink
    assign lm.frac[i] = code_to_frac(lm.code[i]);
  end
endmodule : level_map
`default_nettype wire

/* File: hw/dual_sink_brightness_regs.sv */
// Function
// - Select clear: each sink uses own register
// - Registers eight bits, seven bits set level
// - Top bit ignored for current level
// - Select set: main register drives both sinks
// - Level grows exponentially; code zero off
// - Fixed table entry for all 128 codes
// - Shared select is control bit two
//
// The Avalon-MM interface to the registers is this design's own decision.
`default_nettype none
module dual_sink_brightness_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [brightness_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [brightness_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [brightness_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic [brightness_pkg::CODE_W-1:0] main_code,
  output logic [brightness_pkg::CODE_W-1:0] secondary_code,
  output logic [brightness_pkg::FRAC_W-1:0] main_frac,
  output logic [brightness_pkg::FRAC_W-1:0] secondary_frac,
  output logic main_enable,
  output logic secondary_enable,
  output logic oled_mode,
  output logic [1:0] ramp_select
);
  import brightness_pkg::*;

  bus_state_t bus_state_ff, nxt_bus_state;
  logic wait_ff, nxt_wait;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [5:0] general_ff, nxt_general;
  logic [CODE_W-1:0] main_sink_level_ff, nxt_main_sink_level;
  logic [CODE_W-1:0] secondary_sink_level_ff, nxt_secondary_sink_level;
  logic [CODE_W-1:0] main_code_ff, nxt_main_code;
  logic [CODE_W-1:0] secondary_code_ff, nxt_secondary_code;
  logic [FRAC_W-1:0] main_frac_ff, nxt_main_frac;
  logic [FRAC_W-1:0] secondary_frac_ff, nxt_secondary_frac;
  logic commit;
  logic wr_low;

  level_map_if lm_bus ();

  level_map u_map (
    .lm(lm_bus.mapper)
  );

  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0] addr,
    input logic [5:0] gen,
    input logic [CODE_W-1:0] lvl_main,
    input logic [CODE_W-1:0] lvl_sec
  );
    case (addr)
      OFS_GENERAL:
        read_word = {24'h00_0000, GENERAL_READ_ONES | {2'b00, gen}};
      OFS_MAIN_SINK_LEVEL:
        read_word = {24'h00_0000, LEVEL_READ_ONES | {1'b0, lvl_main}};
      OFS_SECONDARY_SINK_LEVEL:
        read_word = {24'h00_0000, LEVEL_READ_ONES | {1'b0, lvl_sec}};
      default:
        read_word = UNMAPPED_READ;
    endcase
  endfunction : read_word

  // Bus handshake: one wait cycle, then waitrequest low for one edge
  always_comb begin
    nxt_bus_state = bus_state_ff;
    nxt_wait = wait_ff;
    nxt_rdata = rdata_ff;
    case (bus_state_ff)
      BUS_IDLE: begin
        nxt_wait = 1'b1;
        if (read || write) begin
          nxt_bus_state = BUS_ANSWER;
          nxt_wait = 1'b0;
          nxt_rdata = read_word(address, general_ff, main_sink_level_ff,
            secondary_sink_level_ff);
        end
      end
      BUS_ANSWER: begin
        nxt_bus_state = BUS_IDLE;
        nxt_wait = 1'b1;
      end
      default: begin
        nxt_bus_state = BUS_IDLE;
        nxt_wait = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_state_ff <= BUS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= UNMAPPED_READ;
    end else begin
      bus_state_ff <= nxt_bus_state;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // A write lands only at the edge where waitrequest is seen low
  assign commit = (bus_state_ff == BUS_ANSWER) && write && !read;
  assign wr_low = commit && byteenable[0];

  always_comb begin
    nxt_general = general_ff;
    nxt_main_sink_level = main_sink_level_ff;
    nxt_secondary_sink_level = secondary_sink_level_ff;
    if (wr_low) begin
      case (address)
        OFS_GENERAL:
          nxt_general = writedata[5:0] & GENERAL_STORED_MASK[5:0];
        // Top bit of the byte is dropped on purpose
        OFS_MAIN_SINK_LEVEL:
          nxt_main_sink_level = writedata[CODE_W-1:0];
        OFS_SECONDARY_SINK_LEVEL:
          nxt_secondary_sink_level = writedata[CODE_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      general_ff <= GENERAL_RESET[5:0];
      main_sink_level_ff <= CODE_RESET;
      secondary_sink_level_ff <= CODE_RESET;
    end else begin
      general_ff <= nxt_general;
      main_sink_level_ff <= nxt_main_sink_level;
      secondary_sink_level_ff <= nxt_secondary_sink_level;
    end
  end

  // Effective codes; secondary register kept but unused in shared mode
  always_comb begin
    nxt_main_code = main_sink_level_ff;
    if (general_ff[BIT_SHARED_LEVEL_SELECT]) begin
      nxt_secondary_code = main_sink_level_ff;
    end else begin
      nxt_secondary_code = secondary_sink_level_ff;
    end
  end

  assign lm_bus.code[SINK_MAIN] = main_code_ff;
  assign lm_bus.code[SINK_SECONDARY] = secondary_code_ff;

  always_comb begin
    nxt_main_frac = lm_bus.frac[SINK_MAIN];
    nxt_secondary_frac = lm_bus.frac[SINK_SECONDARY];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      main_code_ff <= CODE_RESET;
      secondary_code_ff <= CODE_RESET;
      main_frac_ff <= '0;
      secondary_frac_ff <= '0;
    end else begin
      main_code_ff <= nxt_main_code;
      secondary_code_ff <= nxt_secondary_code;
      main_frac_ff <= nxt_main_frac;
      secondary_frac_ff <= nxt_secondary_frac;
    end
  end

  assign readdata = rdata_ff;
  assign waitrequest = wait_ff;
  assign main_code = main_code_ff;
  assign secondary_code = secondary_code_ff;
  assign main_frac = main_frac_ff;
  assign secondary_frac = secondary_frac_ff;
  assign main_enable = general_ff[BIT_MAIN_ENABLE];
  assign secondary_enable = general_ff[BIT_SECONDARY_ENABLE];
  assign oled_mode = general_ff[BIT_OLED_MODE];
  assign ramp_select = {general_ff[BIT_RAMP1], general_ff[BIT_RAMP0]};
endmodule : dual_sink_brightness_regs
`default_nettype wire

/* File: testbench/brightness_chk_sva.sv */
`default_nettype none
module brightness_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [6:0] main_code,
  input wire logic [6:0] secondary_code,
  input wire logic [16:0] main_frac,
  input wire logic [16:0] secondary_frac
);
  import brightness_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic lvl;
  assign lvl = address == 8'ha0 || address == 8'hb0;
  sequence s_main_wr;
    write && !read && !waitrequest && byteenable[0] && address == 8'ha0;
  endsequence
  sequence s_rd;
    read && !waitrequest;
  endsequence
  AST_WAIT_ONE: assert property ((read || write) && waitrequest |=>
    !waitrequest) else $error("no answer");
  AST_WAIT_PULSE: assert property (!waitrequest |=> waitrequest)
    else $error("answer too long");
  AST_CODE_LAG: assert property (s_main_wr |-> ##2
    main_code == $past(writedata[6:0], 2)) else $error("main code");
  AST_FRAC_ZERO: assert property (main_code == 7'h00 |=>
    main_frac == 17'h00000) else $error("zero level");
  AST_FRAC_FULL: assert property (secondary_code == 7'h7f |=>
    secondary_frac == 17'h186a0) else $error("full level");
  AST_READ_MSB: assert property (s_rd ##0 lvl |->
    readdata[31:7] == 25'h0000001) else $error("level read");
  AST_UNMAPPED: assert property (s_rd ##0 (!lvl && address != 8'h10)
    |-> readdata == 32'h0) else $error("unmapped read");
  AST_READ_CODE: assert property (s_rd ##0 address == 8'ha0 |->
    readdata[6:0] == main_code) else $error("main readback");
endmodule : brightness_chk
bind dual_sink_brightness_regs brightness_chk chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .main_code(main_code),
  .secondary_code(secondary_code), .main_frac(main_frac),
  .secondary_frac(secondary_frac));
`default_nettype wire

/* File: testbench/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import brightness_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic [6:0] main_code, secondary_code, sc;
  logic [16:0] main_frac, secondary_frac;
  logic main_enable, secondary_enable, oled_mode;
  logic [1:0] ramp_select;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h00013010;
  logic [6:0] codes[5] = '{7'h00, 7'h01, 7'h40, 7'h60, 7'h7f};
  logic [16:0] fr[5] = '{17'h0, 17'ha6, 17'hfee, 17'h50e9, 17'h186a0};
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #10 clk_sys = ~clk_sys;
  dual_sink_brightness_regs dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .main_code(main_code),
    .secondary_code(secondary_code), .main_frac(main_frac),
    .secondary_frac(secondary_frac), .main_enable(main_enable),
    .secondary_enable(secondary_enable), .oled_mode(oled_mode),
    .ramp_select(ramp_select));
  function automatic logic [31:0] xorshift(logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xorshift = t ^ (t << 5);
  endfunction : xorshift
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Holds the request until waitrequest is seen low, then idles a cycle
  task automatic bus(logic rd, logic [7:0] a, logic [31:0] d);
    read <= rd;
    write <= !rd;
    address <= a;
    writedata <= d;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0) @(posedge clk_sys);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b1, a, 32'h0);
  endtask : rd
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (rst_n && read && waitrequest === 1'b0)
      check("readdata", readdata, exp_q.pop_front());
    if (cycles == 3000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(OFS_GENERAL, 32'hc0);
    rd(OFS_MAIN_SINK_LEVEL, 32'h80);
    rd(OFS_SECONDARY_SINK_LEVEL, 32'h80);
    for (int i = 0; i < 5; i++) begin
      seed = xorshift(seed);
      sc = seed[6:0];
      bus(1'b0, OFS_MAIN_SINK_LEVEL, {25'h1, codes[i]});
      bus(1'b0, OFS_SECONDARY_SINK_LEVEL, seed);
      repeat (2) @(posedge clk_sys);
      check("main_code", main_code, codes[i]);
      check("main_frac", main_frac, fr[i]);
      check("secondary_code", secondary_code, sc);
      rd(OFS_SECONDARY_SINK_LEVEL, {25'h1, sc});
      bus(1'b0, OFS_GENERAL, 32'h4);
      repeat (2) @(posedge clk_sys);
      check("shared_code", secondary_code, codes[i]);
      check("shared_frac", secondary_frac, fr[i]);
      bus(1'b0, OFS_GENERAL, 32'h0);
    end
    rd(8'h20, 32'h0);
    bus(1'b0, 8'h20, 32'h55);
    byteenable <= 4'he;
    bus(1'b0, OFS_MAIN_SINK_LEVEL, 32'h11);
    byteenable <= 4'hf;
    rd(OFS_MAIN_SINK_LEVEL, 32'hff);
    bus(1'b0, OFS_GENERAL, 32'h3b);
    check("main_enable", main_enable, 1'b1);
    check("secondary_enable", secondary_enable, 1'b1);
    check("oled_mode", oled_mode, 1'b1);
    check("ramp_select", ramp_select, 2'b11);
    rd(OFS_GENERAL, 32'hfb);
    // Reset again in mid-run: levels must fall back to their reset code
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(OFS_MAIN_SINK_LEVEL, 32'h80);
    repeat (2) @(posedge clk_sys);
    check("main_code_rst", main_code, 7'h00);
    check("main_frac_rst", main_frac, 17'h0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
